// ### ucg_consts.svh
// Operation
// - Baud down-counter reloads at zero or low write
// - One tick per zero: sys clock over divisor+1
// - Divisor is twelve bits over two registers
// - Transmit bit rate: baud over 16, 8, 2
// - Receiver uses baud ticks, 16/8/2 sample states
// - Double speed halves divide and receive samples
// - Double speed only in asynchronous mode
// - Mode bit one selects synchronous operation
// - Clock pin direction selects master or slave
// - Transfer clock pin ignored when asynchronous
// - Slave clock synchronised then edge detected, two cycles
// - Sample on edge opposite to data change
// - Polarity zero: change rising, sample falling
// - One transmit buffer allows back-to-back frames
// - Two-entry receive buffer; framing, overrun, parity errors
// - Three interrupt sources: TX done, empty, RX
`ifndef UCG_CONSTS_SVH
`define UCG_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UCG_OFS_DATA 8'h00
`define UCG_OFS_CSA 8'h04
`define UCG_OFS_CSB 8'h08
`define UCG_OFS_CSC 8'h0C
`define UCG_OFS_DIVL 8'h10
`define UCG_OFS_DIVH 8'h14
`define UCG_OFS_IRQST 8'h18
`define UCG_OFS_IRQMASK 8'h1C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UCG_CSA_RXC 7
`define UCG_CSA_TXC 6
`define UCG_CSA_UDRE 5
`define UCG_CSA_FE 4
`define UCG_CSA_DOR 3
`define UCG_CSA_PE 2
`define UCG_CSA_DBL 1
`define UCG_CSB_RXEN 0
`define UCG_CSB_TXEN 1
`define UCG_CSB_PCUT 2
`define UCG_IRQ_RXC 0
`define UCG_IRQ_UDRE 1
`define UCG_IRQ_TXC 2

// ----------------------------------------------------------------
// Widths, reset values and divide ratios
// ----------------------------------------------------------------
`define UCG_DIV_W 12
`define UCG_DIVH_W 4
`define UCG_CSC_RST 8'h06
`define UCG_CSB_RST 3'h0
`define UCG_DIV_ASYNC 5'h10
`define UCG_DIV_DBL 5'h08
`define UCG_CHAR_BASE 4'h5
`define UCG_CHAR_MAX 4'h8
`define UCG_RXBUF_DEPTH 2'h2

`endif

// ### ucg_pkg.sv
package ucg_pkg;

  // Layout matches the control_status_c register, bit 7 first
  typedef struct packed {
    logic clkDirOut;
    logic syncMode;
    logic [1:0] parity;
    logic twoStop;
    logic [1:0] charSize;
    logic clkPol;
  } ucg_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic fe;
    logic pe;
  } ucg_rx_entry_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP1 = 3'b100,
    TX_STOP2 = 3'b101
  } ucg_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } ucg_rx_state_t;

endpackage

// ### ucg_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "ucg_consts.svh"

module ucg_baud_gen #(
  parameter int DIV_W = `UCG_DIV_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic reload,
  input wire logic enable,
  output logic tick
);

  logic [DIV_W-1:0] cntQ;
  logic [DIV_W-1:0] cntD;
  wire atZero = (cntQ == '0);

  // ----------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------
  // Held at the divisor while disabled so restart is clean
  assign cntD = (!enable || reload || atZero) ? divisor :
                cntQ - {{(DIV_W-1){1'b0}}, 1'b1};

  // Enable pulse rather than a derived clock net
  assign tick = enable && atZero && !reload;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cntQ <= '0;
    end else begin
      cntQ <= cntD;
    end
  end

endmodule
`default_nettype wire

// ### ucg_usart_clkgen.sv
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ucg_consts.svh"

module ucg_usart_clkgen #(
  parameter int DIV_W = `UCG_DIV_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic receivePin,
  output logic transmitPin,
  input wire logic transferClockIn,
  output logic transferClockOut,
  output logic transferClockOe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] sampleLim(input logic dbl);
    sampleLim = dbl ? `UCG_DIV_DBL : `UCG_DIV_ASYNC;
  endfunction

  function automatic logic [3:0] charBits(input logic [1:0] sz);
    charBits = `UCG_CHAR_BASE + {2'b00, sz};
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic ackQ;
  logic [31:0] datQ;
  logic [7:0] rdMux;
  wire acc = wb_cyc_i && wb_stb_i && !ackQ;
  wire wrEn = acc && wb_we_i && wb_sel_i[0];
  wire rdEn = acc && !wb_we_i;
  wire [7:0] wd = wb_dat_i[7:0];
  wire hitData = (wb_adr_i == `UCG_OFS_DATA);
  wire hitCsa = (wb_adr_i == `UCG_OFS_CSA);
  wire hitCsb = (wb_adr_i == `UCG_OFS_CSB);
  wire hitCsc = (wb_adr_i == `UCG_OFS_CSC);
  wire hitDivL = (wb_adr_i == `UCG_OFS_DIVL);
  wire hitDivH = (wb_adr_i == `UCG_OFS_DIVH);
  wire hitIrqSt = (wb_adr_i == `UCG_OFS_IRQST);
  wire hitIrqMask = (wb_adr_i == `UCG_OFS_IRQMASK);
  wire wrData = wrEn && hitData;
  wire wrCsa = wrEn && hitCsa;
  wire wrDivL = wrEn && hitDivL;
  wire rdData = rdEn && hitData;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic dblSpeedQ;
  logic [2:0] csbQ;
  logic [7:0] cscQ;
  logic [7:0] divLowQ;
  logic [`UCG_DIVH_W-1:0] divHighQ;
  logic [2:0] irqStQ;
  logic [2:0] irqMaskQ;

  ucg_pkg::ucg_cfg_t cfg;
  assign cfg = ucg_pkg::ucg_cfg_t'(cscQ);

  wire syncMode = cfg.syncMode;
  wire dblEff = dblSpeedQ && !syncMode;
  wire isMaster = syncMode && cfg.clkDirOut;
  wire isSlave = syncMode && !cfg.clkDirOut;
  // Power cut stops baud, transmitter, receiver and clock drive; reset leaves it clear
  wire powered = !csbQ[`UCG_CSB_PCUT];
  wire rxEn = csbQ[`UCG_CSB_RXEN] && powered;
  wire txEn = csbQ[`UCG_CSB_TXEN] && powered;
  wire [4:0] lim = sampleLim(dblEff);
  wire [3:0] limM1 = 4'(lim - 5'h01);
  wire [3:0] halfM1 = 4'((lim >> 1) - 5'h01);
  wire [3:0] nBits = charBits(cfg.charSize);

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  logic tick;
  ucg_baud_gen #(.DIV_W(DIV_W)) uBaud (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .divisor({divHighQ, divLowQ}),
    .reload(wrDivL),
    .enable(powered),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Transfer clock: master toggle and slave synchroniser
  // ----------------------------------------------------------------
  logic mClkQ;
  logic xs1Q;
  logic xs2Q;
  logic xs3Q;
  // Slave edges are seen two cycles after the pin moves
  wire sRise = isSlave && xs2Q && !xs3Q;
  wire sFall = isSlave && !xs2Q && xs3Q;
  // Master clock toggles per tick, giving baud over two
  wire mRise = isMaster && tick && !mClkQ;
  wire mFall = isMaster && tick && mClkQ;
  wire pinRise = isMaster ? mRise : sRise;
  wire pinFall = isMaster ? mFall : sFall;
  wire chgEv = cfg.clkPol ? pinFall : pinRise;
  wire smpEv = cfg.clkPol ? pinRise : pinFall;

  assign transferClockOut = mClkQ;
  assign transferClockOe = isMaster && powered;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xs1Q <= 1'b0;
      xs2Q <= 1'b0;
      xs3Q <= 1'b0;
      mClkQ <= 1'b0;
    end else begin
      xs1Q <= transferClockIn;
      xs2Q <= xs1Q;
      xs3Q <= xs2Q;
      mClkQ <= isMaster ? (mClkQ ^ tick) : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  ucg_pkg::ucg_tx_state_t txStQ;
  logic [3:0] txPreQ;
  logic [7:0] txBufQ;
  logic txFullQ;
  logic [7:0] txShQ;
  logic [3:0] txCntQ;
  logic txParQ;
  logic txPinQ;

  wire txAsyncEv = !syncMode && tick && (txPreQ == limM1);
  wire txBitEv = txEn && (syncMode ? chgEv : txAsyncEv);
  wire txEnding = (txStQ == ucg_pkg::TX_STOP2) ||
                  (txStQ == ucg_pkg::TX_STOP1 && !cfg.twoStop);
  wire txReady = (txStQ == ucg_pkg::TX_IDLE) || txEnding;
  // Reload straight from the buffer at the last stop bit
  wire txLoad = txBitEv && txFullQ && txReady;
  wire evUdre = txLoad;
  wire evTxc = txBitEv && txEnding && !txFullQ;

  assign transmitPin = txEn ? txPinQ : 1'b1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txPreQ <= 4'h0;
      txBufQ <= 8'h00;
      txFullQ <= 1'b0;
    end else begin
      if (syncMode || !txEn) begin
        txPreQ <= 4'h0;
      end else if (tick) begin
        txPreQ <= (txPreQ == limM1) ? 4'h0 : txPreQ + 4'h1;
      end
      if (wrData && !txFullQ) begin
        txBufQ <= wd;
      end
      txFullQ <= (txFullQ && !txLoad) || (wrData && !txFullQ);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txStQ <= ucg_pkg::TX_IDLE;
      txShQ <= 8'h00;
      txCntQ <= 4'h0;
      txParQ <= 1'b0;
      txPinQ <= 1'b1;
    end else if (!txEn) begin
      txStQ <= ucg_pkg::TX_IDLE;
      txPinQ <= 1'b1;
    end else if (txLoad) begin
      txShQ <= txBufQ;
      txParQ <= cfg.parity[0];
      txPinQ <= 1'b0;
      txStQ <= ucg_pkg::TX_START;
    end else if (txBitEv) begin
      case (txStQ)
        ucg_pkg::TX_START, ucg_pkg::TX_DATA: begin
          if (txStQ == ucg_pkg::TX_DATA && txCntQ == nBits) begin
            txPinQ <= cfg.parity[1] ? txParQ : 1'b1;
            txStQ <= cfg.parity[1] ? ucg_pkg::TX_PAR : ucg_pkg::TX_STOP1;
          end else begin
            txPinQ <= txShQ[0];
            txParQ <= txParQ ^ txShQ[0];
            txShQ <= {1'b0, txShQ[7:1]};
            txCntQ <= (txStQ == ucg_pkg::TX_START) ? 4'h1 : txCntQ + 4'h1;
            txStQ <= ucg_pkg::TX_DATA;
          end
        end
        ucg_pkg::TX_PAR: begin
          txPinQ <= 1'b1;
          txStQ <= ucg_pkg::TX_STOP1;
        end
        ucg_pkg::TX_STOP1: begin
          txStQ <= cfg.twoStop ? ucg_pkg::TX_STOP2 : ucg_pkg::TX_IDLE;
        end
        default: begin
          txPinQ <= 1'b1;
          txStQ <= ucg_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  ucg_pkg::ucg_rx_state_t rxStQ;
  logic [3:0] rxScQ;
  logic [7:0] rxShQ;
  logic [3:0] rxCntQ;
  logic rxParQ;
  logic rxPeQ;
  ucg_pkg::ucg_rx_entry_t rxMemQ [0:1];
  logic rxWrQ;
  logic rxRdQ;
  logic [1:0] rxCntBufQ;
  logic dorQ;

  wire rxIdle = (rxStQ == ucg_pkg::RX_IDLE);
  // Async sampling sits mid-bit: half a bit for start, then whole bits
  wire [3:0] scTarget = (rxStQ == ucg_pkg::RX_START) ? halfM1 : limM1;
  wire rxSmp = rxEn && (syncMode ? smpEv :
               (tick && !rxIdle && rxScQ == scTarget));
  wire rxStartAsync = rxEn && !syncMode && tick && rxIdle && !receivePin;
  wire rxStartSync = rxEn && syncMode && smpEv && rxIdle && !receivePin;
  wire rxPush = rxSmp && (rxStQ == ucg_pkg::RX_STOP);
  wire rxFull = (rxCntBufQ == `UCG_RXBUF_DEPTH);
  wire rxNotEmpty = (rxCntBufQ != 2'h0);
  wire rxPop = rdData && rxNotEmpty;
  wire evRxc = rxPush && !rxFull;
  wire [7:0] rxAligned = rxShQ >> (`UCG_CHAR_MAX - nBits);
  ucg_pkg::ucg_rx_entry_t rxHead;
  assign rxHead = rxMemQ[rxRdQ];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxStQ <= ucg_pkg::RX_IDLE;
      rxScQ <= 4'h0;
      rxShQ <= 8'h00;
      rxCntQ <= 4'h0;
      rxParQ <= 1'b0;
      rxPeQ <= 1'b0;
    end else if (!rxEn) begin
      rxStQ <= ucg_pkg::RX_IDLE;
    end else if (rxStartAsync || rxStartSync) begin
      rxScQ <= 4'h0;
      rxCntQ <= 4'h0;
      rxParQ <= cfg.parity[0];
      rxPeQ <= 1'b0;
      rxStQ <= rxStartSync ? ucg_pkg::RX_DATA : ucg_pkg::RX_START;
    end else begin
      if (rxSmp) begin
        rxScQ <= 4'h0;
      end else if (tick) begin
        rxScQ <= rxScQ + 4'h1;
      end
      if (rxSmp) begin
        case (rxStQ)
          // False start: line back high at mid start bit
          ucg_pkg::RX_START: begin
            rxStQ <= receivePin ? ucg_pkg::RX_IDLE : ucg_pkg::RX_DATA;
          end
          ucg_pkg::RX_DATA: begin
            rxShQ <= {receivePin, rxShQ[7:1]};
            rxParQ <= rxParQ ^ receivePin;
            rxCntQ <= rxCntQ + 4'h1;
            if (rxCntQ + 4'h1 == nBits) begin
              rxStQ <= cfg.parity[1] ? ucg_pkg::RX_PAR : ucg_pkg::RX_STOP;
            end
          end
          ucg_pkg::RX_PAR: begin
            rxPeQ <= receivePin ^ rxParQ;
            rxStQ <= ucg_pkg::RX_STOP;
          end
          default: begin
            rxStQ <= ucg_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // Two-entry buffer; a frame arriving while full is dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMemQ[0] <= '0;
      rxMemQ[1] <= '0;
      rxWrQ <= 1'b0;
      rxRdQ <= 1'b0;
      rxCntBufQ <= 2'h0;
      dorQ <= 1'b0;
    end else begin
      if (evRxc) begin
        rxMemQ[rxWrQ] <= '{data: rxAligned, fe: !receivePin,
                           pe: rxPeQ};
        rxWrQ <= !rxWrQ;
      end
      if (rxPop) begin
        rxRdQ <= !rxRdQ;
      end
      rxCntBufQ <= rxCntBufQ + {1'b0, evRxc} - {1'b0, rxPop};
      dorQ <= (rxPush && rxFull) || (dorQ && !rxPop);
    end
  end

  // ----------------------------------------------------------------
  // Status, interrupts and register writes
  // ----------------------------------------------------------------
  logic txcQ;
  wire [2:0] evAll = {evTxc, evUdre, evRxc};
  wire [2:0] irqClr = (wrEn && hitIrqSt) ? wd[2:0] : 3'h0;
  wire txcClr = wrCsa && wd[`UCG_CSA_TXC];

  assign irq = |(irqStQ & irqMaskQ);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dblSpeedQ <= 1'b0;
      csbQ <= `UCG_CSB_RST;
      cscQ <= `UCG_CSC_RST;
      divLowQ <= 8'h00;
      divHighQ <= '0;
      irqMaskQ <= 3'h0;
      irqStQ <= 3'h0;
      txcQ <= 1'b0;
    end else begin
      if (wrCsa) begin
        dblSpeedQ <= wd[`UCG_CSA_DBL];
      end
      if (wrEn && hitCsb) begin
        csbQ <= wd[2:0];
      end
      if (wrEn && hitCsc) begin
        cscQ <= wd;
      end
      if (wrDivL) begin
        divLowQ <= wd;
      end
      if (wrEn && hitDivH) begin
        divHighQ <= wd[`UCG_DIVH_W-1:0];
      end
      if (wrEn && hitIrqMask) begin
        irqMaskQ <= wd[2:0];
      end
      // An event in the clearing cycle wins
      irqStQ <= (irqStQ & ~irqClr) | evAll;
      txcQ <= (txcQ && !txcClr) || evTxc;
    end
  end

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    if (hitData) begin
      rdMux = rxHead.data;
    end else if (hitCsa) begin
      rdMux = {rxNotEmpty, txcQ, !txFullQ, rxHead.fe && rxNotEmpty, dorQ,
               rxHead.pe && rxNotEmpty, dblSpeedQ, 1'b0};
    end else if (hitCsb) begin
      rdMux = {5'h00, csbQ};
    end else if (hitCsc) begin
      rdMux = cscQ;
    end else if (hitDivL) begin
      rdMux = divLowQ;
    end else if (hitDivH) begin
      rdMux = {{(8-`UCG_DIVH_W){1'b0}}, divHighQ};
    end else if (hitIrqSt) begin
      rdMux = {5'h00, irqStQ};
    end else if (hitIrqMask) begin
      rdMux = {5'h00, irqMaskQ};
    end else begin
      rdMux = 8'h00;
    end
  end

  assign wb_ack_o = ackQ;
  assign wb_dat_o = datQ;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackQ <= 1'b0;
      datQ <= 32'h00000000;
    end else begin
      ackQ <= acc;
      if (rdEn) begin
        datQ <= {24'h000000, rdMux};
      end
    end
  end

endmodule
`default_nettype wire

// ### ucg_usart_clkgen_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ucg_usart_clkgen_chk #(
  parameter int DIV_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq,
  input wire logic transmitPin,
  input wire logic transferClockOut,
  input wire logic transferClockOe
);
  // ----------------------------------------------------------------
  // Shadow of software writes
  // ----------------------------------------------------------------
  logic [1:0] mode_q;
  logic pcut_q;
  logic [2:0] mask_q;
  logic [DIV_W-1:0] div_q;
  logic prevOut_q;
  logic armed_q;
  logic [15:0] gap_q;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wrTake = req && wb_we_i && wb_sel_i[0];
  wire rdTake = req && !wb_we_i;
  wire master = mode_q == 2'h3 && !pcut_q;
  wire tog = transferClockOut != prevOut_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 2'h0;
      pcut_q <= 1'h0;
      mask_q <= 3'h0;
      div_q <= {DIV_W{1'h0}};
    end else if (wrTake) begin
      case (wb_adr_i)
        8'h08: pcut_q <= wb_dat_i[2];
        8'h0C: mode_q <= wb_dat_i[7:6];
        8'h10: div_q[7:0] <= wb_dat_i[7:0];
        8'h14: div_q[DIV_W-1:8] <= wb_dat_i[DIV_W-9:0];
        8'h1C: mask_q <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end
  // Writes may shift clock phase, so they disarm the period check
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevOut_q <= 1'h0;
      armed_q <= 1'h0;
      gap_q <= 16'h0;
    end else begin
      prevOut_q <= transferClockOut;
      armed_q <= !wrTake && (armed_q || tog);
      gap_q <= tog ? 16'h0001 : gap_q + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_ack_once;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack not a one-cycle pulse");
  property p_ack_cause;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_read_zero;
    rdTake |=> wb_dat_o[31:8] == 24'h000000
      && (wb_adr_i <= 8'h1C || wb_dat_o[7:0] == 8'h00);
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("bad read data");
  property p_reset_state;
    $rose(rst_n) |-> transmitPin && !transferClockOe && !irq;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("pins not idle after reset");
  property p_oe_off;
    !master && !$past(master) |-> !transferClockOe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("clock pin driven as slave");
  property p_oe_on;
    master && $past(master) |-> transferClockOe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("master clock pin not driven");
  property p_clk_idle;
    (!transferClockOe) [*3] |-> !transferClockOut;
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("idle clock moves");
  property p_clk_period;
    tog && armed_q && master |-> gap_q == 16'(div_q) + 16'h0001;
  endproperty
  a_clk_period: assert property (p_clk_period)
    else $error("clock half period wrong");
  property p_irq_masked;
    mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("masked interrupt raised");
  c_clk_period: cover property (tog && armed_q && master);
  c_irq: cover property (irq);
  c_unmapped: cover property (rdTake && wb_adr_i > 8'h1C);
endmodule
bind ucg_usart_clkgen ucg_usart_clkgen_chk #(.DIV_W(DIV_W)) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq(irq), .transmitPin(transmitPin),
  .transferClockOut(transferClockOut), .transferClockOe(transferClockOe)
);
`default_nettype wire

// ### ucg_remote_model.sv
`timescale 1ns/10ps
`default_nettype none
module ucg_remote_model #(
  parameter int HALF = 5
) (
  input wire logic sys_clk,
  input wire logic transmitPin,
  output logic receivePin,
  output logic transferClockIn
);
  int cyc = 0;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end
  initial begin
    receivePin = 1'h1;
    transferClockIn = 1'h0;
  end
  // ----------------------------------------------------------------
  // Frames: start 0, data LSB first, stop 1
  // ----------------------------------------------------------------
  task automatic idle(input logic pol);
    @(posedge sys_clk);
    transferClockIn <= pol;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic sendByte(input int bitCyc, input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      receivePin <= f[i];
      repeat (bitCyc) @(posedge sys_clk);
    end
  endtask
  task automatic catchByte(input int bitCyc, output logic [7:0] d,
      output int t0, output logic ok);
    int n = 0;
    d = 8'h00;
    while (transmitPin !== 1'h0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    t0 = cyc;
    repeat (bitCyc / 2) @(posedge sys_clk);
    ok = transmitPin === 1'h0 && n < 4000;
    for (int i = 0; i < 8; i++) begin
      repeat (bitCyc) @(posedge sys_clk);
      d[i] = transmitPin;
    end
    repeat (bitCyc) @(posedge sys_clk);
    ok = ok && transmitPin === 1'h1;
  endtask
  // Clock runs fourteen periods: the ten-bit frame, then four with the line held high
  task automatic syncXfer(input logic pol, input logic [7:0] d,
      output logic [7:0] got, output logic ok);
    logic [9:0] f;
    logic [13:0] s;
    int k = 0;
    f = {1'h1, d, 1'h0};
    for (int i = 0; i < 14; i++) begin
      @(posedge sys_clk);
      transferClockIn <= !pol;
      receivePin <= i < 10 ? f[i] : 1'h1;
      repeat (HALF) @(posedge sys_clk);
      transferClockIn <= pol;
      s[i] = transmitPin;
      repeat (HALF - 1) @(posedge sys_clk);
    end
    while (s[k] !== 1'h0 && k < 4) k++;
    got = s[k+1 +: 8];
    ok = s[k] === 1'h0 && s[k+9] === 1'h1;
  endtask
endmodule
`default_nettype wire

// ### ucg_usart_clkgen_test.sv
`timescale 1ns/10ps
`default_nettype none
module ucg_usart_clkgen_test;
  logic sys_clk, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq;
  logic receivePin, transmitPin, transferClockIn;
  logic transferClockOut, transferClockOe;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdv;
  logic [3:0] wb_sel_i;
  int miscompares = 0;
  int checks = 0;
  ucg_usart_clkgen #(.DIV_W(12)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq), .receivePin(receivePin),
    .transmitPin(transmitPin), .transferClockIn(transferClockIn),
    .transferClockOut(transferClockOut), .transferClockOe(transferClockOe)
  );
  ucg_remote_model remote (
    .sys_clk(sys_clk), .transmitPin(transmitPin),
    .receivePin(receivePin), .transferClockIn(transferClockIn)
  );
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bail(input logic hit);
    if (hit) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic wbXfer(input logic we, input logic [7:0] adr,
      input logic [7:0] dat);
    int n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rdv = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    bail(n >= 20);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    wbXfer(1'h1, adr, dat);
  endtask
  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    wbXfer(1'h0, adr, 8'h00);
    cmpVal(rdv, exp);
  endtask
  task automatic waitFlag(input logic [7:0] adr, input int b);
    int n = 0;
    do begin
      wbXfer(1'h0, adr, 8'h00);
      n++;
    end while (rdv[b] !== 1'h1 && n < 400);
    bail(n >= 400);
  endtask
  task automatic waitOut(input logic v, inout int n);
    while (transferClockOut !== v && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    bail(n >= 500);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testRegs();
    rdChk(8'h0C, 32'h06);
    rdChk(8'h08, 32'h00);
    rdChk(8'h10, 32'h00);
    wr(8'h14, 8'hFF);
    wr(8'h10, 8'hFF);
    rdChk(8'h14, 32'h0F);
    rdChk(8'h10, 32'hFF);
    wr(8'h24, 8'h55);
    rdChk(8'h24, 32'h00);
    $display("regs done");
  endtask
  task automatic testAsync();
    logic [7:0] d1, d2;
    int t1, t2;
    logic ok1, ok2;
    wr(8'h14, 8'h00);
    wr(8'h10, 8'h01);
    wr(8'h08, 8'h03);
    fork
      begin
        remote.catchByte(32, d1, t1, ok1);
        remote.catchByte(32, d2, t2, ok2);
      end
      begin
        wr(8'h00, 8'hA5);
        waitFlag(8'h04, 5);
        wr(8'h00, 8'h3C);
      end
    join
    cmpVal({14'h0, ok1, ok2, d1, d2}, 32'h3A53C);
    cmpVal(t2 - t1, 32'h140);
    fork
      remote.catchByte(16, d1, t1, ok1);
      begin
        wr(8'h04, 8'h02);
        wr(8'h00, 8'h96);
      end
    join
    cmpVal({23'h0, ok1, d1}, 32'h196);
    waitFlag(8'h04, 6);
    wr(8'h1C, 8'h04);
    cmpVal({31'h0, irq}, 32'h1);
    rdChk(8'h18, 32'h06);
    wr(8'h18, 8'h04);
    cmpVal({31'h0, irq}, 32'h0);
    wr(8'h1C, 8'h01);
    remote.sendByte(16, 8'h5A);
    waitFlag(8'h04, 7);
    cmpVal({31'h0, irq}, 32'h1);
    rdChk(8'h00, 32'h5A);
    wr(8'h18, 8'h01);
    wr(8'h1C, 8'h00);
    $display("async done");
  endtask
  task automatic testSyncMaster();
    int n1, n2;
    wr(8'h04, 8'h00);
    wr(8'h10, 8'h02);
    wr(8'h0C, 8'hC6);
    n1 = 0;
    waitOut(1'h0, n1);
    waitOut(1'h1, n1);
    n2 = n1;
    waitOut(1'h0, n2);
    waitOut(1'h1, n2);
    cmpVal(n2 - n1, 32'h6);
    cmpVal({31'h0, transferClockOe}, 32'h1);
    wr(8'h0C, 8'h06);
    repeat (4) @(posedge sys_clk);
    cmpVal({30'h0, transferClockOe, transferClockOut}, 32'h0);
    $display("master done");
  endtask
  task automatic testSyncSlave(input logic pol);
    logic [7:0] got;
    logic ok;
    remote.idle(pol);
    wr(8'h0C, {7'h23, pol});
    wr(8'h00, 8'hC5);
    remote.syncXfer(pol, 8'h3A, got, ok);
    cmpVal({23'h0, ok, got}, 32'h1C5);
    waitFlag(8'h04, 7);
    rdChk(8'h00, 32'h3A);
    $display("slave done");
  endtask
  initial begin
    rst_n = 1'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    wb_we_i = 1'h0;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'h1;
    testRegs();
    testAsync();
    testSyncMaster();
    testSyncSlave(1'h0);
    testSyncSlave(1'h1);
    conclude();
  end
endmodule
`default_nettype wire
